// file: common/scsp_cfg.svh
`ifndef SCSP_CFG_SVH
`define SCSP_CFG_SVH
`define SCSP_CHAR_W      8
`define SCSP_FIFO_DEPTH  4
`define SCSP_FIFO_AW     2
`define SCSP_BUSY_TOKEN  8'hff
`define SCSP_MODE_W      2
`define SCSP_MODE_SPI    2'h2
`define SCSP_MODE_I2C    2'h3
`define SCSP_LIN_W       4
`define SCSP_EXP_W       4
`define SCSP_CNT_W       16
`define SCSP_REF_MHZ     12
`define SCSP_CLK_MHZ     125
`define SCSP_SSEL_NONE   3'h0
`define SCSP_SSEL_SAVED  3'h1
`define SCSP_SSEL_MORE   3'h2
`endif

// file: common/scsp_pkg.sv
`include "scsp_cfg.svh"
package scsp_pkg;
  typedef logic [`SCSP_CHAR_W-1:0] scsp_char_t;
  typedef enum logic [2:0] {
    SCSP_IDLE  = 3'b001,
    SCSP_SHIFT = 3'b010,
    SCSP_DONE  = 3'b100
  } scsp_state_t;
endpackage : scsp_pkg

// file: hw/scsp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module scsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic      [AW:0]      count_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;
  // honest flags from the occupancy count
  assign in_ready_o  = (count_o < (AW+1)'(DEPTH));
  assign out_valid_o = (count_o != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rd_ptr];
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || flush_i) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count_o <= '0;
    end else if (ce_i) begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count_o <= count_o + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // storage has no reset, contents are qualified by count
  always_ff @(posedge core_clk_i) begin
    if (ce_i && push) mem[wr_ptr] <= in_data_i;
  end
endmodule : scsp_fifo
`default_nettype wire

// file: hw/scsp_slave.sv
// Operation
// - output enable on the master-in line only while select is low
// - select falling edge resets both shift registers
// - four-entry transmit and receive fifos shared by software and dma
// - storing a received character sets rx valid
// - full receive fifo drops character, sets overflow and overrun irq
// - dma error reported only once receive fifo has drained
// - dma error cleared by dma reset bit or buffer reload
// - each received character starts a transmit; empty fifo flags underrun
// - underrun sends last character or busy token per repeat bit
// - write into empty fifo and idle serializer clears tx idle
// - tx free clears on full fifo, sets on each shifted character
// - tx idle sets when fifo empty and last character shifted
// - after select and rx valid, data into empty fifo gets padding first
// - padding value follows repeat bit
// - first select rise after load saves active receive count
// - later rises set status; three-bit field records save history
// - idle, free, valid irqs by edge or level per mode bit
// - irqs on buffer active falling edges, overrun and underrun
// - irq out only when enabled locally and at top level
// - mode value three selects i2c master, master only
// - scl from 12.5 MHz divided by (lin+1) times 2 to exp
`timescale 1ns/1ps
`default_nettype none
`include "scsp_cfg.svh"
module scsp_slave (
  input  wire logic                       core_clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       ce_i,
  input  wire logic                       sclk_i,
  input  wire logic                       slave_select_n_i,
  input  wire logic                       mosi_i,
  output logic                            miso_o,
  output logic                            miso_oe_o,
  input  wire logic [`SCSP_MODE_W-1:0]    serial_mode_i,
  input  wire logic                       repeat_last_select_i,
  input  wire logic                       irq_edge_level_select_i,
  input  wire logic [6:0]                 serial_irq_enable_i,
  input  wire logic                       serial_top_irq_enable_i,
  input  wire logic                       tx_wr_valid_i,
  output logic                            tx_wr_ready_o,
  input  wire scsp_pkg::scsp_char_t       tx_wr_data_i,
  input  wire logic                       rx_rd_i,
  output scsp_pkg::scsp_char_t            rx_rd_data_o,
  input  wire logic [3:0]                 buffer_active_ab_i,
  input  wire logic                       rx_dma_active_i,
  input  wire logic                       rx_buffer_load_i,
  input  wire logic                       rx_dma_reset_i,
  input  wire logic [`SCSP_CNT_W-1:0]     rx_dma_count_i,
  output logic [`SCSP_CNT_W-1:0]          rx_count_saved_o,
  output logic [2:0]                      select_edge_save_field_o,
  output logic                            rx_dma_error_o,
  output logic                            rx_valid_flag_o,
  output logic                            rx_overflow_flag_o,
  output logic                            tx_idle_flag_o,
  output logic                            tx_free_flag_o,
  output logic [6:0]                      serial_irq_flag_o,
  output logic                            irq_o,
  input  wire logic [`SCSP_LIN_W-1:0]     rate_linear_i,
  input  wire logic [`SCSP_EXP_W-1:0]     rate_exponent_i,
  output logic                            i2c_mode_o,
  output logic                            scl_o,
  output logic                            scl_oe_o
);
  import scsp_pkg::*;

  // two-flop synchronisers for pins; first stage read only by second
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       sclk_d;
  logic       ssn_d;
  logic       sclk_s;
  logic       ssn_s;
  logic       mosi_s;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sync1  <= 3'h2; // pin idle levels: clock low, select high, data low
      sync2  <= 3'h2; // a clock stage reset high would fake a rise after reset
      sclk_d <= 1'b0;
      ssn_d  <= 1'b1;
    end else if (ce_i) begin
      sync1  <= {sclk_i, slave_select_n_i, mosi_i};
      sync2  <= sync1;
      sclk_d <= sync2[2];
      ssn_d  <= sync2[1];
    end
  end
  assign sclk_s = sync2[2];
  assign ssn_s  = sync2[1];
  assign mosi_s = sync2[0];

  logic spi_on;
  logic sel_fall;
  logic sel_rise;
  logic sclk_rise;
  logic sclk_fall;
  assign spi_on    = (serial_mode_i == `SCSP_MODE_SPI);
  assign sel_fall  = ssn_d & ~ssn_s;
  assign sel_rise  = ~ssn_d & ssn_s;
  // mode 0 timing only: sample on rise, shift on fall
  assign sclk_rise = ~sclk_d & sclk_s & ~ssn_s & spi_on;
  assign sclk_fall = sclk_d & ~sclk_s & ~ssn_s & spi_on;

  // transmit buffering: 8-word staging fifo ahead of the 4-entry tx fifo
  logic       stg_valid;
  logic       stg_ready;
  scsp_char_t stg_data;
  scsp_fifo #(.WIDTH(`SCSP_CHAR_W), .DEPTH(8), .AW(3)) u_stage (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .flush_i     (1'b0),
    .in_valid_i  (tx_wr_valid_i),
    .in_ready_o  (tx_wr_ready_o),
    .in_data_i   (tx_wr_data_i),
    .out_valid_o (stg_valid),
    .out_ready_i (stg_ready),
    .out_data_o  (stg_data),
    .count_o     ()
  );

  logic       tx_push;
  scsp_char_t tx_push_data;
  logic       tx_pop;
  logic       tx_ready;
  logic       tx_valid;
  scsp_char_t tx_head;
  logic [2:0] tx_count;
  logic       pad_armed;
  logic       pad_push;
  scsp_char_t last_tx;
  scsp_char_t filler;
  // padding enters the fifo as if written by software
  assign filler       = repeat_last_select_i ? last_tx : `SCSP_BUSY_TOKEN;
  assign pad_push     = pad_armed & (tx_count == 3'h0) & stg_valid & ~ssn_s;
  assign stg_ready    = tx_ready & ~pad_push;
  assign tx_push      = (stg_valid & tx_ready) | pad_push;
  assign tx_push_data = pad_push ? filler : stg_data;
  scsp_fifo #(.WIDTH(`SCSP_CHAR_W), .DEPTH(`SCSP_FIFO_DEPTH), .AW(`SCSP_FIFO_AW)) u_txf (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .flush_i     (1'b0),
    .in_valid_i  (tx_push),
    .in_ready_o  (tx_ready),
    .in_data_i   (tx_push_data),
    .out_valid_o (tx_valid),
    .out_ready_i (tx_pop),
    .out_data_o  (tx_head),
    .count_o     (tx_count)
  );

  logic       rx_push;
  logic       rx_ready;
  logic       rx_valid;
  scsp_char_t rx_char;
  logic [2:0] rx_count;
  scsp_fifo #(.WIDTH(`SCSP_CHAR_W), .DEPTH(`SCSP_FIFO_DEPTH), .AW(`SCSP_FIFO_AW)) u_rxf (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .flush_i     (1'b0),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_ready),
    .in_data_i   (rx_char),
    .out_valid_o (rx_valid),
    .out_ready_i (rx_rd_i),
    .out_data_o  (rx_rd_data_o),
    .count_o     (rx_count)
  );

  // bit shifters, msb first, eight bits per character
  scsp_state_t state;
  scsp_char_t  rx_sh;
  scsp_char_t  tx_sh;
  logic [2:0]  bit_cnt;
  logic        char_done;
  logic        ser_busy;
  assign char_done = sclk_rise & (bit_cnt == 3'h7);
  assign rx_char   = {rx_sh[6:0], mosi_s};
  assign rx_push   = char_done & rx_ready;
  assign tx_pop    = char_done & tx_valid;
  assign ser_busy  = (state == SCSP_SHIFT);
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state   <= SCSP_IDLE;
      rx_sh   <= 8'h00;
      tx_sh   <= `SCSP_BUSY_TOKEN;
      bit_cnt <= 3'h0;
      last_tx <= `SCSP_BUSY_TOKEN;
    end else if (ce_i) begin
      if (sel_fall) begin
        state   <= SCSP_IDLE;
        rx_sh   <= 8'h00;
        bit_cnt <= 3'h0;
        tx_sh   <= `SCSP_BUSY_TOKEN; // first character after select never comes from the fifo
      end else if (sclk_rise) begin
        rx_sh   <= rx_char;
        bit_cnt <= bit_cnt + 3'h1;
        state   <= (bit_cnt == 3'h7) ? SCSP_DONE : SCSP_SHIFT;
        if (bit_cnt == 3'h7) begin
          // load in the cycle of the pop, so the popped character is the one sent
          tx_sh   <= tx_valid ? tx_head : (repeat_last_select_i ? {tx_sh[6:0], tx_sh[7]} : `SCSP_BUSY_TOKEN);
          last_tx <= {tx_sh[6:0], tx_sh[7]};
        end
      end else if (sclk_fall) begin
        case (state)
          SCSP_DONE: state <= SCSP_IDLE;
          default:   tx_sh <= {tx_sh[6:0], tx_sh[7]}; // rotate: one more turn at the last rise restores it
        endcase
      end
    end
  end

  // master-in pin driven only while selected
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
    end else if (ce_i) begin
      miso_o    <= tx_sh[7];
      miso_oe_o <= ~ssn_s & spi_on;
    end
  end

  // padding arms once rx valid seen within a selection
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pad_armed <= 1'b0;
    end else if (ce_i) begin
      if (ssn_s) pad_armed <= 1'b0;
      else if (rx_push) pad_armed <= 1'b1;
    end
  end

  // status flags; hardware set wins over clear, except tx idle, where a push into the empty fifo clears it
  logic tx_under_ev;
  logic rx_over_ev;
  assign tx_under_ev = char_done & ~tx_valid;
  assign rx_over_ev  = char_done & ~rx_ready;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rx_valid_flag_o    <= 1'b0;
      rx_overflow_flag_o <= 1'b0;
      tx_idle_flag_o     <= 1'b1;
      tx_free_flag_o     <= 1'b1;
    end else if (ce_i) begin
      rx_valid_flag_o <= rx_valid | rx_push;
      if (rx_over_ev) rx_overflow_flag_o <= 1'b1;
      else if (rx_rd_i) rx_overflow_flag_o <= 1'b0;
      if (tx_push && tx_count == 3'h0 && !ser_busy) tx_idle_flag_o <= 1'b0;
      else if (tx_count == 3'h0 && !tx_valid && state == SCSP_IDLE && bit_cnt == 3'h0)
        tx_idle_flag_o <= 1'b1;
      if (tx_pop) tx_free_flag_o <= 1'b1;
      else if (tx_push && tx_count == 3'(`SCSP_FIFO_DEPTH - 1)) tx_free_flag_o <= 1'b0;
    end
  end

  // dma error deferred until the receive fifo drains
  logic err_pending;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      err_pending    <= 1'b0;
      rx_dma_error_o <= 1'b0;
    end else if (ce_i) begin
      if (rx_over_ev) err_pending <= 1'b1;
      else if (rx_count == 3'h0) err_pending <= 1'b0;
      if (err_pending && rx_count == 3'h0) rx_dma_error_o <= 1'b1;
      else if (rx_dma_reset_i || rx_buffer_load_i) rx_dma_error_o <= 1'b0;
    end
  end

  // saved count on first select rise after a load
  logic save_armed;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      save_armed               <= 1'b0;
      rx_count_saved_o         <= '0;
      select_edge_save_field_o <= `SCSP_SSEL_NONE;
    end else if (ce_i) begin
      if (rx_buffer_load_i) begin
        save_armed               <= 1'b1;
        select_edge_save_field_o <= `SCSP_SSEL_NONE;
      end else if (sel_rise && rx_dma_active_i) begin
        if (save_armed) begin
          rx_count_saved_o         <= rx_dma_count_i;
          save_armed               <= 1'b0;
          select_edge_save_field_o <= `SCSP_SSEL_SAVED;
        end else begin
          select_edge_save_field_o <= select_edge_save_field_o | `SCSP_SSEL_MORE;
        end
      end
    end
  end

  // second-level flags: idle, free, valid, tx act, rx act, overrun, underrun
  logic [2:0] lvl;
  logic [2:0] lvl_d;
  logic [3:0] act_d;
  logic [6:0] ev;
  assign lvl = {rx_valid_flag_o, tx_free_flag_o, tx_idle_flag_o};
  assign ev  = {tx_under_ev, rx_over_ev,
                |(act_d[3:2] & ~buffer_active_ab_i[3:2]),
                |(act_d[1:0] & ~buffer_active_ab_i[1:0]),
                irq_edge_level_select_i ? lvl : (lvl & ~lvl_d)};
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      lvl_d             <= 3'h3; // idle and free leave reset high: no false edge
      act_d             <= 4'h0;
      serial_irq_flag_o <= 7'h00;
      irq_o             <= 1'b0;
    end else if (ce_i) begin
      lvl_d             <= lvl;
      act_d             <= buffer_active_ab_i;
      serial_irq_flag_o <= ev | serial_irq_flag_o & ~(7'h7f & {7{1'b0}});
      irq_o             <= serial_top_irq_enable_i & |(serial_irq_flag_o & serial_irq_enable_i);
    end
  end

  // i2c clock: 12.5 MHz tick then (lin+1)*2^exp divide
  localparam int REF_DIV = `SCSP_CLK_MHZ / `SCSP_REF_MHZ;
  logic [3:0]  ref_cnt;
  logic [19:0] div_cnt;
  logic [19:0] div_lim;
  assign div_lim = 20'((({16'h0, rate_linear_i} + 20'h1) << rate_exponent_i) >> 1); // half period
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ref_cnt    <= 4'h0;
      div_cnt    <= 20'h0;
      scl_o      <= 1'b0;
      scl_oe_o   <= 1'b0;
      i2c_mode_o <= 1'b0;
    end else if (ce_i) begin
      i2c_mode_o <= (serial_mode_i == `SCSP_MODE_I2C);
      ref_cnt    <= (ref_cnt == 4'(REF_DIV - 1)) ? 4'h0 : ref_cnt + 4'h1;
      if (serial_mode_i != `SCSP_MODE_I2C) begin
        div_cnt  <= 20'h0;
        scl_oe_o <= 1'b0;
      end else if (ref_cnt == 4'h0) begin
        if (div_cnt + 20'h1 >= div_lim) begin
          div_cnt  <= 20'h0;
          scl_oe_o <= ~scl_oe_o; // open drain: enable pulls low
        end else begin
          div_cnt <= div_cnt + 20'h1;
        end
      end
    end
  end

  a_sel_oe: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && ssn_s |=> !miso_oe_o) else $error("output driven while deselected");
  a_sel_reset: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && sel_fall |=> bit_cnt == 3'h0) else $error("shift not reset on select");
  a_rx_overrun: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && rx_over_ev |=> rx_overflow_flag_o && serial_irq_flag_o[5]) else $error("overrun missed");
  a_tx_underrun: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && tx_under_ev |=> serial_irq_flag_o[6]) else $error("underrun missed");
  a_busy_token: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && tx_under_ev && !repeat_last_select_i |=> tx_sh == 8'hff) else $error("wrong filler");
  a_rx_valid: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && rx_push |=> rx_valid_flag_o) else $error("rx valid not set");
  a_irq_gate: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && !serial_top_irq_enable_i |=> !irq_o) else $error("irq leaked");
  a_dma_err: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && $rose(rx_dma_error_o) |-> $past(rx_count) == 3'h0) else $error("early dma error");
endmodule : scsp_slave
`default_nettype wire

// file: sim/scsp_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module scsp_spi_master #(
  parameter int HALF_NS = 128
) (
  output logic      sclk_o,
  output logic      slave_select_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  // clock stands low outside frames
  initial begin
    sclk_o = 1'b0;
    slave_select_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // select goes low well before the first clock edge
  task automatic select_dev();
    slave_select_n_o = 1'b0;
    #(4*HALF_NS);
  endtask : select_dev
  // mode 0, msb first, eight bits a character
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      #(HALF_NS);
      sclk_o = 1'b1;
      rx[i] = miso_i;
      #(HALF_NS);
      sclk_o = 1'b0;
    end
    #(2*HALF_NS);
  endtask : xfer
  // released data line shows the inverse, never a stale value
  task automatic deselect_dev();
    slave_select_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #(4*HALF_NS);
  endtask : deselect_dev
endmodule : scsp_spi_master
`default_nettype wire

// file: sim/serial_ctrl_spi_slave_i2c_setup_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scsp_cfg.svh"
module serial_ctrl_spi_slave_i2c_setup_tb_top;
  import scsp_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i, ce_i, sclk_i, slave_select_n_i, mosi_i, miso_o, miso_oe_o, miso_w;
  logic [`SCSP_MODE_W-1:0] serial_mode_i;
  logic repeat_last_select_i, irq_edge_level_select_i, serial_top_irq_enable_i, irq_o;
  logic [6:0] serial_irq_enable_i, serial_irq_flag_o;
  logic tx_wr_valid_i, tx_wr_ready_o, rx_rd_i, rx_dma_active_i, rx_buffer_load_i, rx_dma_reset_i;
  scsp_char_t tx_wr_data_i, rx_rd_data_o;
  logic [3:0] buffer_active_ab_i, rate_linear_i, rate_exponent_i;
  logic [`SCSP_CNT_W-1:0] rx_dma_count_i, rx_count_saved_o, saved;
  logic [2:0] select_edge_save_field_o;
  logic rx_dma_error_o, rx_valid_flag_o, rx_overflow_flag_o, tx_idle_flag_o, tx_free_flag_o;
  logic i2c_mode_o, scl_o, scl_oe_o;
  int fail_count = 0;
  int samples_checked = 0;
  int p;
  always #4 core_clk_i = ~core_clk_i;
  // undriven line seen by the master shows the inverse
  assign miso_w = miso_oe_o ? miso_o : ~miso_o;
  scsp_slave DUT (.core_clk_i, .rstn_i, .ce_i, .sclk_i, .slave_select_n_i, .mosi_i, .miso_o, .miso_oe_o,
    .serial_mode_i, .repeat_last_select_i, .irq_edge_level_select_i, .serial_irq_enable_i,
    .serial_top_irq_enable_i, .tx_wr_valid_i, .tx_wr_ready_o, .tx_wr_data_i, .rx_rd_i, .rx_rd_data_o,
    .buffer_active_ab_i, .rx_dma_active_i, .rx_buffer_load_i, .rx_dma_reset_i, .rx_dma_count_i,
    .rx_count_saved_o, .select_edge_save_field_o, .rx_dma_error_o, .rx_valid_flag_o, .rx_overflow_flag_o,
    .tx_idle_flag_o, .tx_free_flag_o, .serial_irq_flag_o, .irq_o, .rate_linear_i, .rate_exponent_i,
    .i2c_mode_o, .scl_o, .scl_oe_o);
  scsp_spi_master M (.sclk_o(sclk_i), .slave_select_n_o(slave_select_n_i), .mosi_o(mosi_i), .miso_i(miso_w));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checked=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc
  // hold valid and data until an edge passes with ready high
  task automatic wr(input scsp_char_t d);
    int n;
    n = 0;
    @(negedge core_clk_i);
    tx_wr_valid_i = 1'b1;
    tx_wr_data_i = d;
    while (tx_wr_ready_o !== 1'b1) begin
      @(negedge core_clk_i);
      n++;
      if (n > 400) begin
        fail_count++;
        test_done();
      end
    end
    @(negedge core_clk_i);
    tx_wr_valid_i = 1'b0;
  endtask : wr
  task automatic pulse(ref logic s);
    @(negedge core_clk_i);
    s = 1'b1;
    @(negedge core_clk_i);
    s = 1'b0;
    cyc(3);
  endtask : pulse
  // queue model of the transmit path: pops on each character, pad on refill
  task automatic run_frame(input logic rep, input int npre, input int nby);
    scsp_char_t q[$];
    scsp_char_t sent[$];
    scsp_char_t last, x, r;
    @(negedge core_clk_i);
    repeat_last_select_i = rep;
    for (int i = 0; i < npre; i++) begin
      x = 8'($urandom);
      wr(x);
      q.push_back(x);
    end
    cyc(4);
    if (npre > 0) chk(16'(tx_idle_flag_o), 16'h0);
    if (npre >= 12) chk(16'({tx_free_flag_o, tx_wr_ready_o}), 16'h0);
    M.select_dev();
    chk(16'(miso_oe_o), 16'h1);
    for (int k = 1; k <= nby; k++) begin
      x = 8'($urandom);
      sent.push_back(x);
      M.xfer(x, r);
      chk(16'(r), (k > 1) ? 16'(last) : 16'(`SCSP_BUSY_TOKEN));
      if (q.size() > 0) last = q.pop_front();
      else if (!rep) last = `SCSP_BUSY_TOKEN;
      if (k == 4) begin
        x = 8'($urandom);
        wr(x);
        if (q.size() == 0) q.push_back(rep ? last : `SCSP_BUSY_TOKEN);
        q.push_back(x);
      end
    end
    chk(16'({rx_valid_flag_o, rx_overflow_flag_o, serial_irq_flag_o[6:5]}), 16'hf);
    M.deselect_dev();
    cyc(4);
    chk(16'({miso_oe_o, tx_idle_flag_o, tx_free_flag_o}), 16'h3);
    // fifo keeps the first four, later characters were dropped
    for (int i = 0; i < 4; i++) begin
      chk(16'(rx_rd_data_o), 16'(sent[i]));
      pulse(rx_rd_i);
    end
    chk(16'(rx_dma_error_o), 16'h1);
    $display("frame done rep=%0d pre=%0d bytes=%0d", rep, npre, nby);
  endtask : run_frame
  // hang guard
  initial begin
    #600us;
    fail_count++;
    test_done();
  end
  initial begin
    rstn_i = 1'b0;
    ce_i = 1'b1;
    serial_mode_i = `SCSP_MODE_SPI;
    repeat_last_select_i = 1'b1;
    irq_edge_level_select_i = 1'b1;
    serial_irq_enable_i = 7'h7f;
    serial_top_irq_enable_i = 1'b0;
    tx_wr_valid_i = 1'b0;
    tx_wr_data_i = 8'h00;
    rx_rd_i = 1'b0;
    buffer_active_ab_i = 4'hf;
    rx_dma_active_i = 1'b1;
    rx_buffer_load_i = 1'b0;
    rx_dma_reset_i = 1'b0;
    rx_dma_count_i = 16'h0000;
    rate_linear_i = 4'he;
    rate_exponent_i = 4'h1;
    void'($urandom(95));
    cyc(8);
    rstn_i = 1'b1;
    cyc(1);
    chk(16'({tx_idle_flag_o, tx_free_flag_o, rx_valid_flag_o, miso_oe_o, irq_o}), 16'h18);
    saved = 16'($urandom);
    rx_dma_count_i = saved;
    pulse(rx_buffer_load_i);
    run_frame(1'b1, 2, 7);
    chk(rx_count_saved_o, saved);
    chk(16'(select_edge_save_field_o[1:0]), 16'h1);
    pulse(rx_dma_reset_i);
    chk(16'(rx_dma_error_o), 16'h0);
    rx_dma_count_i = ~saved;
    run_frame(1'b0, 0, 7);
    chk(rx_count_saved_o, saved);
    chk(16'(select_edge_save_field_o[1]), 16'h1);
    pulse(rx_buffer_load_i);
    chk(16'(rx_dma_error_o), 16'h0);
    run_frame(1'b1, 12, 15);
    buffer_active_ab_i = 4'h0;
    cyc(4);
    chk(16'({serial_irq_flag_o[3:0], irq_o}), 16'h1e);
    serial_top_irq_enable_i = 1'b1;
    cyc(4);
    chk(16'(irq_o), 16'h1);
    serial_irq_enable_i = 7'h00;
    cyc(4);
    chk(16'(irq_o), 16'h0);
    serial_mode_i = `SCSP_MODE_I2C;
    cyc(4);
    chk(16'({i2c_mode_o, miso_oe_o, scl_o}), 16'h4);
    // one full scl period, measured between rising edges of the pull-down
    p = 0;
    while (scl_oe_o !== 1'b0 && p < 2000) begin cyc(1); p++; end
    while (scl_oe_o !== 1'b1 && p < 2000) begin cyc(1); p++; end
    p = 0;
    while (scl_oe_o === 1'b1 && p < 2000) begin cyc(1); p++; end
    while (scl_oe_o === 1'b0 && p < 2000) begin cyc(1); p++; end
    chk(16'(p), 16'((14 + 1) * 2 * (`SCSP_CLK_MHZ / `SCSP_REF_MHZ)));
    $display("irq and i2c tests done");
    // second reset in edge mode: idle and free stay high, so no edge may be flagged
    rstn_i = 1'b0;
    irq_edge_level_select_i = 1'b0;
    serial_mode_i = `SCSP_MODE_SPI;
    cyc(2);
    rstn_i = 1'b1;
    cyc(4);
    chk(16'(serial_irq_flag_o[2:0]), 16'h0);
    $display("edge mode reset test done");
    test_done();
  end
endmodule : serial_ctrl_spi_slave_i2c_setup_tb_top
`default_nettype wire
